// [common/alu_decoder_pkg.sv]
// Purpose: shared constants and types for the instruction decode and execute block
// Assumes: 14-bit instruction word, 8-bit data path, 13-bit program counter
// Notes: opcodes are matched on the upper bits of the word
package alu_decoder_pkg;

  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int ADDR_W = 7;
  localparam int PHASES = 4;

  // Opcode fields, top three to eleven bits of the word
  localparam logic [5:0] OP_ADD_REG = 6'h07;
  localparam logic [5:0] OP_AND_REG = 6'h05;
  localparam logic [5:0] OP_SUB_REG = 6'h02;
  localparam logic [5:0] OP_SWAP_REG = 6'h0E;
  localparam logic [5:0] OP_AND_LIT = 6'h39;
  localparam logic [4:0] OP_ADD_LIT = 5'h1F;
  localparam logic [3:0] OP_BIT_SKIP = 4'h7;
  localparam logic [2:0] OP_CALL = 3'h4;
  localparam logic [10:0] OP_DIR_LOAD = 11'h00C;

  // Field positions
  localparam int DEST_BIT = 7;
  localparam int BIT_SEL_LSB = 7;
  localparam int CALL_LIT_W = 11;
  localparam int LATCH_LO = 3;
  localparam int LATCH_HI = 4;
  localparam int NIBBLE = 4;

  // Direction register selector range
  localparam logic [2:0] DIR_FIRST = 3'h5;
  localparam logic [2:0] DIR_LAST = 3'h7;

  typedef enum logic [1:0] {
    PH_DECODE = 2'b00,
    PH_READ = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE = 2'b11
  } phase_e;

  typedef enum logic [3:0] {
    K_NOP = 4'h0,
    K_ADD_REG = 4'h1,
    K_AND_REG = 4'h2,
    K_SUB_REG = 4'h3,
    K_SWAP_REG = 4'h4,
    K_ADD_LIT = 4'h5,
    K_AND_LIT = 4'h6,
    K_BIT_SKIP = 4'h7,
    K_CALL = 4'h8,
    K_DIR_LOAD = 4'h9
  } kind_e;

  // Decoded instruction as it travels from decoder to executor
  typedef struct packed {
    kind_e kind;
    logic to_reg;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] lit;
    logic [CALL_LIT_W-1:0] target;
    logic [2:0] bit_sel;
  } decoded_s;

  // Status flag group
  typedef struct packed {
    logic carry;
    logic nibble;
    logic zero;
  } flags_s;

endpackage : alu_decoder_pkg

// [src/instr_field_decoder.sv]
// Purpose: split a 14-bit instruction word into a decoded record
// Assumes: word is stable for the whole cycle it is decoded in
// Notes: pure combinational; unknown words decode to a no-operation
`timescale 1ns/1ps
`default_nettype none
module instr_field_decoder (
  input wire logic [alu_decoder_pkg::WORD_W-1:0] word_in,
  output alu_decoder_pkg::decoded_s dec_out
);

  // Opcode match, widest pattern first so overlaps cannot alias
  always_comb begin
    dec_out = '0;
    dec_out.kind = alu_decoder_pkg::K_NOP;
    dec_out.to_reg = word_in[alu_decoder_pkg::DEST_BIT];
    dec_out.addr = word_in[alu_decoder_pkg::ADDR_W-1:0];
    dec_out.lit = word_in[alu_decoder_pkg::DATA_W-1:0];
    dec_out.target = word_in[alu_decoder_pkg::CALL_LIT_W-1:0];
    dec_out.bit_sel = word_in[alu_decoder_pkg::BIT_SEL_LSB +: 3];
    if (word_in[13:3] == alu_decoder_pkg::OP_DIR_LOAD) begin
      dec_out.kind = alu_decoder_pkg::K_DIR_LOAD;
    end else if (word_in[13:8] == alu_decoder_pkg::OP_ADD_REG) begin
      dec_out.kind = alu_decoder_pkg::K_ADD_REG;
    end else if (word_in[13:8] == alu_decoder_pkg::OP_AND_REG) begin
      dec_out.kind = alu_decoder_pkg::K_AND_REG;
    end else if (word_in[13:8] == alu_decoder_pkg::OP_SUB_REG) begin
      dec_out.kind = alu_decoder_pkg::K_SUB_REG;
    end else if (word_in[13:8] == alu_decoder_pkg::OP_SWAP_REG) begin
      dec_out.kind = alu_decoder_pkg::K_SWAP_REG;
    end else if (word_in[13:8] == alu_decoder_pkg::OP_AND_LIT) begin
      dec_out.kind = alu_decoder_pkg::K_AND_LIT;
    end else if (word_in[13:9] == alu_decoder_pkg::OP_ADD_LIT) begin
      dec_out.kind = alu_decoder_pkg::K_ADD_LIT;
    end else if (word_in[13:10] == alu_decoder_pkg::OP_BIT_SKIP) begin
      dec_out.kind = alu_decoder_pkg::K_BIT_SKIP;
    end else if (word_in[13:11] == alu_decoder_pkg::OP_CALL) begin
      dec_out.kind = alu_decoder_pkg::K_CALL;
    end
  end

endmodule : instr_field_decoder
`default_nettype wire

// [src/byte_alu.sv]
// Purpose: 8-bit arithmetic and logic unit with carry and nibble carry
// Assumes: operand a is the register or literal, b is the accumulator
// Notes: subtraction is a minus b, carry out is an inverted borrow
`timescale 1ns/1ps
`default_nettype none
module byte_alu (
  input wire alu_decoder_pkg::kind_e kind_in,
  input wire logic [alu_decoder_pkg::DATA_W-1:0] a_in,
  input wire logic [alu_decoder_pkg::DATA_W-1:0] b_in,
  output logic [alu_decoder_pkg::DATA_W-1:0] result_out,
  output alu_decoder_pkg::flags_s flags_out
);

  localparam int N = alu_decoder_pkg::NIBBLE;

  // Add with carry-in; reused for subtract as a + ~b + 1
  function automatic logic [alu_decoder_pkg::DATA_W:0] add_c(
    input logic [alu_decoder_pkg::DATA_W-1:0] x,
    input logic [alu_decoder_pkg::DATA_W-1:0] y,
    input logic cin
  );
    add_c = {1'b0, x} + {1'b0, y} + {8'h00, cin};
  endfunction : add_c

  function automatic logic [N:0] add_n(
    input logic [N-1:0] x,
    input logic [N-1:0] y,
    input logic cin
  );
    add_n = {1'b0, x} + {1'b0, y} + {4'h0, cin};
  endfunction : add_n

  logic [alu_decoder_pkg::DATA_W:0] sum;
  logic [N:0] low;

  // Result and flags per operation kind
  always_comb begin
    sum = '0;
    low = '0;
    result_out = '0;
    flags_out = '0;
    unique case (kind_in)
      alu_decoder_pkg::K_ADD_REG, alu_decoder_pkg::K_ADD_LIT: begin
        sum = add_c(a_in, b_in, 1'b0);
        low = add_n(a_in[N-1:0], b_in[N-1:0], 1'b0);
      end
      alu_decoder_pkg::K_SUB_REG: begin
        sum = add_c(a_in, ~b_in, 1'b1);
        low = add_n(a_in[N-1:0], ~b_in[N-1:0], 1'b1);
      end
      default: begin
        sum = '0;
        low = '0;
      end
    endcase
    unique case (kind_in)
      alu_decoder_pkg::K_AND_REG, alu_decoder_pkg::K_AND_LIT: result_out = a_in & b_in;
      alu_decoder_pkg::K_SWAP_REG: result_out = {a_in[N-1:0], a_in[7:N]};
      alu_decoder_pkg::K_DIR_LOAD: result_out = b_in;
      default: result_out = sum[alu_decoder_pkg::DATA_W-1:0]; // wraps modulo 256
    endcase
    flags_out.carry = sum[alu_decoder_pkg::DATA_W];
    flags_out.nibble = low[N];
    flags_out.zero = (result_out == 8'h00);
  end

endmodule : byte_alu
`default_nettype wire

// [src/alu_instruction_decoder.sv]
// Purpose: four-phase decode and execute of a subset of the accumulator instruction set
// Assumes: program memory supplies the word for the current counter; register file answers combinationally
// Notes: one instruction cycle is four clocks; call, and skip when the tested bit is set, insert a whole no-operation cycle
`timescale 1ns/1ps
`default_nettype none
module alu_instruction_decoder (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [alu_decoder_pkg::WORD_W-1:0] instr_in,
  input wire logic [alu_decoder_pkg::DATA_W-1:0] reg_rdata_in,
  input wire logic [4:0] pc_high_latch_in,
  output logic [alu_decoder_pkg::PC_W-1:0] pc_out,
  output logic [alu_decoder_pkg::ADDR_W-1:0] reg_addr_out,
  output logic reg_we_out,
  output logic [alu_decoder_pkg::DATA_W-1:0] reg_wdata_out,
  output logic [alu_decoder_pkg::DATA_W-1:0] accum_out,
  output alu_decoder_pkg::flags_s flags_out,
  output logic push_out,
  output logic [alu_decoder_pkg::PC_W-1:0] stack_top_out,
  output logic [2:0] dir_sel_out,
  output logic dir_we_out,
  output logic [alu_decoder_pkg::DATA_W-1:0] dir_wdata_out,
  output alu_decoder_pkg::phase_e phase_out,
  output logic flush_out
);

  alu_decoder_pkg::phase_e phase, next_phase;
  alu_decoder_pkg::decoded_s dec, next_dec, dec_now;
  logic [alu_decoder_pkg::DATA_W-1:0] operand, next_operand;
  logic [alu_decoder_pkg::DATA_W-1:0] result, next_result, alu_result;
  alu_decoder_pkg::flags_s alu_flags, alu_flags_q, next_alu_flags_q;
  logic flush, next_flush;
  logic hold_pc, next_hold_pc;

  logic [alu_decoder_pkg::PC_W-1:0] pc, next_pc;
  logic [alu_decoder_pkg::DATA_W-1:0] accum, next_accum;
  alu_decoder_pkg::flags_s flags, next_flags;
  logic [alu_decoder_pkg::ADDR_W-1:0] reg_addr, next_reg_addr;
  logic reg_we, next_reg_we;
  logic [alu_decoder_pkg::DATA_W-1:0] reg_wdata, next_reg_wdata;
  logic push, next_push;
  logic [alu_decoder_pkg::PC_W-1:0] stack_top, next_stack_top;
  logic [2:0] dir_sel, next_dir_sel;
  logic dir_we, next_dir_we;
  logic [alu_decoder_pkg::DATA_W-1:0] dir_wdata, next_dir_wdata;

  instr_field_decoder u_decode (
    .word_in(instr_in),
    .dec_out(dec_now)
  );

  byte_alu u_alu (
    .kind_in(dec.kind),
    .a_in(operand),
    .b_in(accum),
    .result_out(alu_result),
    .flags_out(alu_flags)
  );

  // Width checks: the call target and the nibble swap are wired for these sizes only
  localparam int LATCH_BITS = alu_decoder_pkg::LATCH_HI - alu_decoder_pkg::LATCH_LO + 1;
  if (alu_decoder_pkg::PC_W != alu_decoder_pkg::CALL_LIT_W + LATCH_BITS) begin : g_pc_width
    $error("program counter width must equal call literal plus latch bits");
  end
  if (alu_decoder_pkg::DATA_W != 2 * alu_decoder_pkg::NIBBLE) begin : g_nibble_width
    $error("data width must be two nibbles");
  end

  // Sequencer and datapath next state; flush turns a whole cycle into a no-operation
  always_comb begin
    next_phase = phase;
    next_dec = dec;
    next_operand = operand;
    next_result = result;
    next_alu_flags_q = alu_flags_q;
    next_flush = flush;
    next_hold_pc = hold_pc;
    next_pc = pc;
    next_accum = accum;
    next_flags = flags;
    next_reg_addr = reg_addr;
    next_reg_we = 1'b0;
    next_reg_wdata = reg_wdata;
    next_push = 1'b0;
    next_stack_top = stack_top;
    next_dir_sel = dir_sel;
    next_dir_we = 1'b0;
    next_dir_wdata = dir_wdata;
    unique case (phase)
      alu_decoder_pkg::PH_DECODE: begin
        next_phase = alu_decoder_pkg::PH_READ;
        next_dec = dec_now;
        if (flush) begin
          next_dec.kind = alu_decoder_pkg::K_NOP;
        end
        next_reg_addr = dec_now.addr;
      end
      alu_decoder_pkg::PH_READ: begin
        next_phase = alu_decoder_pkg::PH_PROCESS;
        unique case (dec.kind)
          alu_decoder_pkg::K_ADD_LIT, alu_decoder_pkg::K_AND_LIT: next_operand = dec.lit;
          default: next_operand = reg_rdata_in;
        endcase
      end
      alu_decoder_pkg::PH_PROCESS: begin
        next_phase = alu_decoder_pkg::PH_WRITE;
        next_result = alu_result;
        next_alu_flags_q = alu_flags;
      end
      alu_decoder_pkg::PH_WRITE: begin
        next_phase = alu_decoder_pkg::PH_DECODE;
        // A call's dead cycle keeps the counter on the target, so the target word runs next
        if (!hold_pc) begin
          next_pc = pc + 13'h0001;
        end
        next_flush = 1'b0;
        next_hold_pc = 1'b0;
        unique case (dec.kind)
          alu_decoder_pkg::K_ADD_REG, alu_decoder_pkg::K_SUB_REG: begin
            next_flags = alu_flags_q;
          end
          alu_decoder_pkg::K_ADD_LIT: begin
            next_flags = alu_flags_q;
            next_accum = result;
          end
          alu_decoder_pkg::K_AND_LIT: begin
            next_flags.zero = alu_flags_q.zero;
            next_accum = result;
          end
          alu_decoder_pkg::K_AND_REG: begin
            next_flags.zero = alu_flags_q.zero;
          end
          alu_decoder_pkg::K_BIT_SKIP: begin
            next_flush = operand[dec.bit_sel];
          end
          alu_decoder_pkg::K_CALL: begin
            next_push = 1'b1;
            next_stack_top = pc + 13'h0001;
            next_pc = {pc_high_latch_in[alu_decoder_pkg::LATCH_HI:alu_decoder_pkg::LATCH_LO], dec.target};
            next_flush = 1'b1;
            next_hold_pc = 1'b1;
          end
          alu_decoder_pkg::K_DIR_LOAD: begin
            if (dec.addr[2:0] >= alu_decoder_pkg::DIR_FIRST && dec.addr[2:0] <= alu_decoder_pkg::DIR_LAST) begin
              next_dir_we = 1'b1;
              next_dir_sel = dec.addr[2:0];
              next_dir_wdata = result;
            end
          end
          default: begin
          end
        endcase
        // Destination routing for register-operand kinds
        if (dec.kind == alu_decoder_pkg::K_ADD_REG || dec.kind == alu_decoder_pkg::K_AND_REG ||
            dec.kind == alu_decoder_pkg::K_SUB_REG || dec.kind == alu_decoder_pkg::K_SWAP_REG) begin
          if (dec.to_reg) begin
            next_reg_we = 1'b1;
            next_reg_wdata = result;
          end else begin
            next_accum = result;
          end
        end
      end
    endcase
  end

  // State registers only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase <= alu_decoder_pkg::PH_DECODE;
      dec <= '0;
      operand <= 8'h00;
      result <= 8'h00;
      alu_flags_q <= '0;
      flush <= 1'b0;
      hold_pc <= 1'b0;
      pc <= 13'h0000;
      accum <= 8'h00;
      flags <= '0;
      reg_addr <= 7'h00;
      reg_we <= 1'b0;
      reg_wdata <= 8'h00;
      push <= 1'b0;
      stack_top <= 13'h0000;
      dir_sel <= 3'h0;
      dir_we <= 1'b0;
      dir_wdata <= 8'h00;
    end else begin
      phase <= next_phase;
      dec <= next_dec;
      operand <= next_operand;
      result <= next_result;
      alu_flags_q <= next_alu_flags_q;
      flush <= next_flush;
      hold_pc <= next_hold_pc;
      pc <= next_pc;
      accum <= next_accum;
      flags <= next_flags;
      reg_addr <= next_reg_addr;
      reg_we <= next_reg_we;
      reg_wdata <= next_reg_wdata;
      push <= next_push;
      stack_top <= next_stack_top;
      dir_sel <= next_dir_sel;
      dir_we <= next_dir_we;
      dir_wdata <= next_dir_wdata;
    end
  end

  assign pc_out = pc;
  assign reg_addr_out = reg_addr;
  assign reg_we_out = reg_we;
  assign reg_wdata_out = reg_wdata;
  assign accum_out = accum;
  assign flags_out = flags;
  assign push_out = push;
  assign stack_top_out = stack_top;
  assign dir_sel_out = dir_sel;
  assign dir_we_out = dir_we;
  assign dir_wdata_out = dir_wdata;
  assign phase_out = phase;
  assign flush_out = flush;

  // Helper sequences for the multi-step behaviours
  sequence s_call_done;
    push && flush;
  endsequence

  // Four phases of a dead cycle
  sequence s_idle_cycle;
    dec.kind == alu_decoder_pkg::K_NOP [*4];
  endsequence

  // Write phase of a kind that updates the zero flag
  sequence s_zero_writer;
    phase == alu_decoder_pkg::PH_WRITE &&
    (dec.kind == alu_decoder_pkg::K_ADD_REG || dec.kind == alu_decoder_pkg::K_SUB_REG ||
     dec.kind == alu_decoder_pkg::K_ADD_LIT || dec.kind == alu_decoder_pkg::K_AND_REG ||
     dec.kind == alu_decoder_pkg::K_AND_LIT);
  endsequence

  // Boundary checks, all sampled on the instruction clock
  a_phase_order: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    phase == alu_decoder_pkg::PH_WRITE |=> phase == alu_decoder_pkg::PH_DECODE)
    else $error("phase did not wrap to decode");
  a_call_push: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    push |-> stack_top == $past(pc) + 13'h0001)
    else $error("pushed address not counter plus one");
  a_call_target: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    push |-> pc[12:11] == $past(pc_high_latch_in[4:3]))
    else $error("call upper bits wrong");
  a_call_two_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_call_done |=> s_idle_cycle)
    else $error("second call cycle not idle");
  a_call_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase == alu_decoder_pkg::PH_WRITE && hold_pc) |=> $stable(pc))
    else $error("counter left the call target during the dead cycle");
  a_skip_nop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase == alu_decoder_pkg::PH_DECODE && flush) |=> dec.kind == alu_decoder_pkg::K_NOP)
    else $error("skipped word not discarded");
  a_skip_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase == alu_decoder_pkg::PH_WRITE && dec.kind == alu_decoder_pkg::K_BIT_SKIP) |=> flush == operand[dec.bit_sel])
    else $error("skip flag does not follow the tested bit");
  a_dest_reg: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_we |-> $stable(accum))
    else $error("accumulator changed on register write");
  a_swap_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase == alu_decoder_pkg::PH_WRITE && dec.kind == alu_decoder_pkg::K_SWAP_REG) |=> $stable(flags))
    else $error("nibble exchange changed flags");
  a_and_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase == alu_decoder_pkg::PH_WRITE && (dec.kind == alu_decoder_pkg::K_AND_REG ||
     dec.kind == alu_decoder_pkg::K_AND_LIT)) |=> $stable(flags.carry) && $stable(flags.nibble))
    else $error("logical operation changed carry flags");
  a_sub_borrow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase == alu_decoder_pkg::PH_WRITE && dec.kind == alu_decoder_pkg::K_SUB_REG)
    |=> flags.carry == (operand >= $past(accum)))
    else $error("subtract carry is not the inverted borrow");
  a_null_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_zero_writer |=> flags.zero == (result == 8'h00))
    else $error("zero flag does not follow the result");
  a_zero_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (phase == alu_decoder_pkg::PH_WRITE && dec.kind == alu_decoder_pkg::K_ADD_LIT)
    |=> flags.zero == (accum == 8'h00))
    else $error("zero flag mismatch");
  a_dir_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dir_we |-> dir_wdata == accum && dir_sel >= 3'h5)
    else $error("direction load wrong");

endmodule : alu_instruction_decoder
`default_nettype wire

// [dv/prog_reg_model.sv]
// Purpose: program memory and data register file seen by the decoder
// Assumes: both answer within the clock, as the decoder samples a phase later
// Notes: unwritten program words read as zero, which decodes to a no-operation
`timescale 1ns/1ps
`default_nettype none
module prog_reg_model (
  input wire logic clk_in,
  input wire logic [alu_decoder_pkg::PC_W-1:0] pc_in,
  input wire logic [alu_decoder_pkg::ADDR_W-1:0] addr_in,
  input wire logic we_in,
  input wire logic [alu_decoder_pkg::DATA_W-1:0] wdata_in,
  output logic [alu_decoder_pkg::WORD_W-1:0] instr_out,
  output logic [alu_decoder_pkg::DATA_W-1:0] rdata_out
);
  logic [alu_decoder_pkg::WORD_W-1:0] rom [0:8191];
  logic [alu_decoder_pkg::DATA_W-1:0] ram [0:127];
  // Plain combinational answers, no wait states
  always_comb begin
    instr_out = rom[pc_in];
    rdata_out = ram[addr_in];
  end
  // Write-back only on the one-clock strobe; plain always since the bench preloads ram too
  always @(posedge clk_in) begin
    if (we_in) begin
      ram[addr_in] <= wdata_in;
    end
  end
endmodule : prog_reg_model
`default_nettype wire

// [dv/alu_instruction_decoder_tb.sv]
// Purpose: self-checking bench for the four-phase decode and execute block
// Assumes: results land at the phase 0 boundary after each instruction cycle
// Notes: after the closing call only its flushed cycle is checked, counter on the target
`timescale 1ns/1ps
`default_nettype none
module alu_instruction_decoder_tb;
  typedef struct packed {
    logic [12:0] pc; logic cpc; logic [7:0] acc; logic [2:0] fl;
    logic we; logic [6:0] ad; logic [7:0] wd; logic push; logic [12:0] stk;
    logic dwe; logic [2:0] ds; logic [7:0] dd; logic fls;
  } note_s;
  logic clk_in, rst_n_in, we, push_out, dir_we_out, flush_out;
  logic [13:0] instr;
  logic [7:0] rdata, wdata, accum_out, dir_wdata_out;
  logic [4:0] pc_high_latch_in;
  logic [12:0] pc_out, stack_top_out;
  logic [6:0] addr;
  logic [2:0] dir_sel_out;
  alu_decoder_pkg::flags_s flags_out;
  alu_decoder_pkg::phase_e phase_out;
  int n_fail, checks_done, seed, cnt;
  note_s q[$];
  logic [7:0] acc, rg [0:127];
  logic c, dc, z, fl_pend, hold;
  logic [12:0] rpc;
  alu_instruction_decoder dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr), .reg_rdata_in(rdata),
    .pc_high_latch_in(pc_high_latch_in), .pc_out(pc_out), .reg_addr_out(addr), .reg_we_out(we),
    .reg_wdata_out(wdata), .accum_out(accum_out), .flags_out(flags_out), .push_out(push_out),
    .stack_top_out(stack_top_out), .dir_sel_out(dir_sel_out), .dir_we_out(dir_we_out),
    .dir_wdata_out(dir_wdata_out), .phase_out(phase_out), .flush_out(flush_out));
  prog_reg_model mdl (.clk_in(clk_in), .pc_in(pc_out), .addr_in(addr), .we_in(we), .wdata_in(wdata),
    .instr_out(instr), .rdata_out(rdata));
  // Shared comparison, four-state exact
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Reference step: one instruction cycle, noted as the expected boundary state
  task automatic step();
    logic [13:0] w; logic [7:0] f, a, b, r; logic [8:0] s; logic [4:0] h; logic rop, ci; note_s n;
    w = mdl.rom[rpc]; f = rg[w[6:0]]; n = '0; n.cpc = 1'b1; rop = 1'b0; ci = 1'b0;
    if (fl_pend) begin
      fl_pend = 1'b0; n.cpc = (w !== 14'h3FFF) && !n.push && (rpc != 13'h1FFF);
      if (hold) rpc = rpc - 13'h1; // Dead cycle after a call refetches the target
      hold = 1'b0;
    end else if (w[13:8] == 6'h07 || w[13:8] == 6'h02 || w[13:9] == 5'h1F) begin
      ci = (w[13:8] == 6'h02); a = (w[13:9] == 5'h1F) ? w[7:0] : f; b = ci ? ~acc : acc;
      s = {1'b0, a} + {1'b0, b} + ci; h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
      r = s[7:0]; c = s[8]; dc = h[4]; z = (r == 8'h00); rop = (w[13:9] != 5'h1F);
      if (!rop) acc = r;
    end else if (w[13:8] == 6'h05 || w[13:8] == 6'h39) begin
      rop = (w[13:8] == 6'h05); r = acc & (rop ? f : w[7:0]); z = (r == 8'h00);
      if (!rop) acc = r;
    end else if (w[13:8] == 6'h0E) begin
      rop = 1'b1; r = {f[3:0], f[7:4]};
    end else if (w[13:10] == 4'h7) begin
      fl_pend = f[w[9:7]];
    end else if (w[13:3] == 11'h00C) begin
      n.dwe = (w[2:0] >= 3'h5); n.ds = n.dwe ? w[2:0] : 3'h0; n.dd = n.dwe ? acc : 8'h00;
    end else if (w[13:11] == 3'h4) begin
      n.push = 1'b1; n.stk = rpc + 13'h1; fl_pend = 1'b1; rpc = {pc_high_latch_in[4:3], w[10:0]} - 13'h1;
      hold = 1'b1;
    end
    if (rop && w[7]) begin
      n.we = 1'b1; n.ad = w[6:0]; n.wd = r; rg[w[6:0]] = r;
    end else if (rop) acc = r;
    rpc = rpc + 13'h1; n.pc = rpc; n.acc = acc; n.fl = {c, dc, z};
    n.fls = fl_pend; // Flush stands from the end of the skipping or calling cycle
    q.push_back(n);
  endtask : step
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Watchdog sized well past the program length
  initial begin
    repeat (2000) @(posedge clk_in);
    n_fail++;
    report_and_stop();
  end
  // Monitor: phase order every clock, boundary state against the oldest note
  always @(negedge clk_in) begin
    if (rst_n_in) begin
      check("phase", phase_out, cnt % 4);
      if (phase_out === alu_decoder_pkg::PH_DECODE && cnt > 0 && q.size() > 0) begin
        note_s n;
        n = q.pop_front();
        check("accum", accum_out, n.acc);
        check("flags", flags_out, n.fl);
        check("reg_we", we, n.we);
        if (n.we) check("reg_write", {addr, wdata}, {n.ad, n.wd});
        check("dir_we", dir_we_out, n.dwe);
        if (n.dwe) check("dir_write", {dir_sel_out, dir_wdata_out}, {n.ds, n.dd});
        check("push", push_out, n.push);
        if (n.push) check("stack_top", stack_top_out, n.stk);
        if (n.cpc) check("pc", pc_out, n.pc);
        check("flush", flush_out, n.fls);
      end
      cnt++;
    end
  end
  initial begin
    logic [13:0] w;
    logic [4:0] lat;
    seed = 32'hb406;
    n_fail = 0; checks_done = 0; cnt = 0;
    rst_n_in = 1'b0; pc_high_latch_in = 5'h00;
    acc = 8'h00; c = 1'b0; dc = 1'b0; z = 1'b0; fl_pend = 1'b0; rpc = 13'h0000;
    hold = 1'b0;
    for (int i = 0; i < 8192; i++) mdl.rom[i] = 14'h0000;
    for (int i = 0; i < 128; i++) begin
      rg[i] = $random(seed);
      mdl.ram[i] = rg[i];
    end
    // Program: every opcode in turn with random operands, a call last
    for (int i = 0; i < 48; i++) begin
      w = $random(seed);
      case (i % 8)
        0: w[13:8] = 6'h07;
        1: w[13:8] = 6'h05;
        2: w[13:8] = 6'h02;
        3: w[13:8] = 6'h0E;
        4: w[13:9] = 5'h1F;
        5: w[13:8] = 6'h39;
        6: w[13:10] = 4'h7;
        default: w = {11'h00C, 1'b1, w[1:0]}; // Legacy load issued only to test it
      endcase
      if (i == 5) w[7:0] = 8'h00; // Forces a zero result early
      mdl.rom[i] = w;
    end
    mdl.rom[48] = {3'h4, 11'h5A3};
    lat = $random(seed);
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    pc_high_latch_in <= lat;
    @(posedge clk_in);
    while (rpc < 13'd49) step();
    step();
    for (int k = 0; k < 600 && q.size() > 0; k++) @(posedge clk_in);
    check("notes_left", q.size(), 0);
    report_and_stop();
  end
endmodule : alu_instruction_decoder_tb
`default_nettype wire
